// >>> logic/bp_map.svh
// Purpose: constants for the branch prediction unit
// Assumes: included by bare name from the store, stack and predictor files
// Notes: counts, counter encodings and reset values only; types live in bp_pkg
`ifndef BP_MAP_SVH
`define BP_MAP_SVH

// ==========================================================
// sizing
// ==========================================================
// address width of linear instruction addresses
`define BP_ADDR_W 32
// entries of the joint history table / target buffer
`define BP_STORE_ENTRIES 256
// entries of the return address stack
`define BP_RAS_DEPTH 16
// bytes in one fetch chunk
`define BP_FETCH_CHUNK 32

// ==========================================================
// history counter encodings
// ==========================================================
// new entry counter, retired taken
`define BP_CNT_NEW_TAKEN 2'h2
// new entry counter, retired not taken
`define BP_CNT_NEW_NOT 2'h1
// saturation limits of the two-bit counter
`define BP_CNT_MAX 2'h3
`define BP_CNT_MIN 2'h0
// counter bit that gives the predicted direction
`define BP_CNT_DIR_BIT 1

// ==========================================================
// reset values
// ==========================================================
`define BP_RST_ADDR 32'h0000_0000
`define BP_RST_FLAG 1'h0

`endif

// >>> logic/bp_pkg.sv
// Purpose: shared types of the branch prediction unit
// Assumes: used as bp_pkg::name, never imported
// Notes: kind codes are set by the decoder and the retirement unit
package bp_pkg;

  // ==========================================================
  // branch kinds seen at decode and retirement
  // ==========================================================
  typedef enum logic [2:0] {
    BP_K_NONE = 3'h0, // not a branch
    BP_K_COND = 3'h1, // near conditional, direct
    BP_K_CALL = 3'h2, // near call
    BP_K_RET = 3'h3, // near return
    BP_K_IND = 3'h4, // near indirect jump
    BP_K_FAR_CALL = 3'h5, // far call
    BP_K_IRET = 3'h6, // interrupt return
    BP_K_SWINT = 3'h7 // software interrupt
  } bp_kind_e;

endpackage : bp_pkg

// >>> logic/bp_pred_store.sv
// Purpose: joint branch history table and target buffer
// Assumes: single clock, reset already synchronised by the caller
// Notes: two read ports (fetch, decode), one write port (retirement)
`timescale 1ns/1ps
`include "bp_map.svh"

module bp_pred_store #(
  parameter int ENTRIES = `BP_STORE_ENTRIES,
  parameter int AW = `BP_ADDR_W
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // fetch-side lookup
  input wire logic [AW-1:0] fa_addr_in,
  output logic fa_hit_out,
  output logic fa_taken_out,
  output logic [AW-1:0] fa_target_out,
  // decode-side lookup
  input wire logic [AW-1:0] da_addr_in,
  output logic da_hit_out,
  output logic da_taken_out,
  output logic [AW-1:0] da_target_out,
  // retirement update
  input wire logic up_valid_in,
  input wire logic [AW-1:0] up_addr_in,
  input wire logic up_taken_in,
  input wire logic [AW-1:0] up_target_in
);

  localparam int IW = $clog2(ENTRIES);

  logic [ENTRIES-1:0] valid_q; // entry holds a live prediction
  logic [AW-IW-1:0] tag_q [ENTRIES]; // upper address bits
  logic [AW-1:0] tgt_q [ENTRIES]; // last resolved target
  logic [1:0] cnt_q [ENTRIES]; // two-bit direction history
  logic [IW-1:0] ui; // update index

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic [IW-1:0] idx_f(input logic [AW-1:0] a);
    return a[IW-1:0];
  endfunction : idx_f

  function automatic logic hit_f(input logic [AW-1:0] a);
    return valid_q[idx_f(a)] && (tag_q[idx_f(a)] == a[AW-1:IW]);
  endfunction : hit_f

  // ==========================================================
  // lookups by linear address
  // ==========================================================
  // both ports read the same store
  always_comb begin
    fa_hit_out = hit_f(fa_addr_in);
    fa_taken_out = cnt_q[idx_f(fa_addr_in)][`BP_CNT_DIR_BIT];
    fa_target_out = tgt_q[idx_f(fa_addr_in)];
    da_hit_out = hit_f(da_addr_in);
    da_taken_out = cnt_q[idx_f(da_addr_in)][`BP_CNT_DIR_BIT];
    da_target_out = tgt_q[idx_f(da_addr_in)];
  end

  // ==========================================================
  // update
  // ==========================================================
  assign ui = idx_f(up_addr_in);

  // reset clears valid bits: first branches go static
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_q <= '0;
    end else if (up_valid_in) begin
      valid_q[ui] <= 1'b1;
    end
  end

  // tag, target, counter: retirement only
  always_ff @(posedge clock_in) begin
    if (up_valid_in) begin
      tag_q[ui] <= up_addr_in[AW-1:IW];
      tgt_q[ui] <= up_target_in;
      if (!hit_f(up_addr_in)) begin
        // new entry starts weak, resolved way
        cnt_q[ui] <= up_taken_in ? `BP_CNT_NEW_TAKEN : `BP_CNT_NEW_NOT;
      end else if (up_taken_in && cnt_q[ui] != `BP_CNT_MAX) begin
        cnt_q[ui] <= cnt_q[ui] + 2'h1;
      end else if (!up_taken_in && cnt_q[ui] != `BP_CNT_MIN) begin
        cnt_q[ui] <= cnt_q[ui] - 2'h1;
      end
    end
  end

endmodule : bp_pred_store

// >>> logic/bp_return_stack.sv
// Purpose: return address stack for near returns
// Assumes: push and pop never asserted together
// Notes: on overflow the oldest entry is overwritten
`timescale 1ns/1ps
`include "bp_map.svh"

module bp_return_stack #(
  parameter int DEPTH = `BP_RAS_DEPTH,
  parameter int AW = `BP_ADDR_W
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // stack operations
  input wire logic push_in,
  input wire logic [AW-1:0] push_addr_in,
  input wire logic pop_in,
  // top of stack
  output logic [AW-1:0] top_out,
  output logic empty_out
);

  localparam int PW = $clog2(DEPTH);

  logic [AW-1:0] mem_q [DEPTH]; // stored return addresses
  logic [PW-1:0] ptr_q; // next free slot
  logic [PW:0] cnt_q; // live entries, 0..DEPTH

  // ==========================================================
  // top of stack view
  // ==========================================================
  always_comb begin
    top_out = mem_q[ptr_q - 1'b1];
    empty_out = (cnt_q == '0);
  end

  // ==========================================================
  // pointer and fill count
  // ==========================================================
  // reset empties the stack
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_q <= '0;
      cnt_q <= '0;
    end else if (push_in) begin
      ptr_q <= ptr_q + 1'b1;
      if (cnt_q != DEPTH[PW:0]) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else if (pop_in && !empty_out) begin
      ptr_q <= ptr_q - 1'b1;
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // storage: one slot written per call
  always_ff @(posedge clock_in) begin
    if (push_in) begin
      mem_q[ptr_q] <= push_addr_in;
    end
  end

endmodule : bp_return_stack

// >>> logic/bp_branch_predictor.sv
// Purpose: front-end branch prediction unit
// Assumes: fetch, decode and retirement run on clock_in
// Notes: predictions are registered, one cycle after the request
`timescale 1ns/1ps
`include "bp_map.svh"

// Summary of operation
// - predict near conditional, call, return, indirect
// - no prediction for far call, iret, swint
// - dynamic direction and target by linear address
// - history table and target buffer act jointly
// - dynamic hit answers before decode, at fetch
// - no dynamic entry: conditional backward taken, forward not
// - static decided at decode by displacement sign
// - sixteen-entry return address stack
// - returns always taken, target from stack
// - correct prediction costs no extra cycle
// - misprediction pays full flush and refetch
// - taken branch and target share trace line
module bp_branch_predictor #(
  parameter int ENTRIES = `BP_STORE_ENTRIES,
  parameter int RAS_DEPTH = `BP_RAS_DEPTH,
  parameter int AW = `BP_ADDR_W
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // fetch lookup
  input wire logic fetch_valid_in,
  input wire logic [AW-1:0] fetch_addr_in,
  output logic fetch_pred_valid_out,
  output logic fetch_pred_hit_out,
  output logic fetch_pred_taken_out,
  output logic [AW-1:0] fetch_pred_target_out,
  output logic [AW-1:0] fetch_next_chunk_out,
  // decode prediction
  input wire logic dec_valid_in,
  input wire logic [AW-1:0] dec_addr_in,
  input wire bp_pkg::bp_kind_e dec_kind_in,
  input wire logic [AW-1:0] dec_disp_in,
  input wire logic [3:0] dec_len_in,
  output logic dec_pred_valid_out,
  output logic dec_pred_made_out,
  output logic dec_pred_static_out,
  output logic dec_pred_taken_out,
  output logic [AW-1:0] dec_pred_target_out,
  // trace builder
  output logic trace_link_out,
  // retirement update
  input wire logic ret_valid_in,
  input wire logic [AW-1:0] ret_addr_in,
  input wire bp_pkg::bp_kind_e ret_kind_in,
  input wire logic ret_taken_in,
  input wire logic [AW-1:0] ret_target_in,
  input wire logic ret_mispredict_in,
  input wire logic [AW-1:0] ret_correct_addr_in,
  // recovery
  output logic flush_out,
  output logic [AW-1:0] redirect_addr_out
);

  // ==========================================================
  // declarations
  // ==========================================================
  logic rst_meta_q; // first reset stage
  logic rst_n_q; // synchronised reset for the whole unit
  // store lookup results
  logic fa_hit;
  logic fa_taken;
  logic [AW-1:0] fa_target;
  logic da_hit;
  logic da_taken;
  logic [AW-1:0] da_target;
  // stack interface
  logic ras_push;
  logic ras_pop;
  logic [AW-1:0] ras_top;
  logic ras_empty;
  // decode results before the register
  logic dec_go; // decode slot live and not flushed
  logic near_d;
  logic static_d;
  logic taken_d;
  logic [AW-1:0] target_d;
  logic [AW-1:0] direct_tgt; // address after the branch plus displacement
  logic [AW-1:0] fall_thru; // address after the branch
  logic upd_go; // retirement writes the store
  // registered outputs
  logic fv_q;
  logic fh_q;
  logic ft_q;
  logic [AW-1:0] ftg_q;
  logic [AW-1:0] fnc_q;
  logic dv_q;
  logic dm_q;
  logic ds_q;
  logic dt_q;
  logic [AW-1:0] dtg_q;
  logic tl_q;
  logic fl_q;
  logic [AW-1:0] rd_q;

  // ==========================================================
  // helpers
  // ==========================================================
  // branch kinds that get a prediction
  function automatic logic is_near_f(input bp_pkg::bp_kind_e k);
    return (k == bp_pkg::BP_K_COND) || (k == bp_pkg::BP_K_CALL) ||
           (k == bp_pkg::BP_K_RET) || (k == bp_pkg::BP_K_IND);
  endfunction : is_near_f

  // fetch chunk base of an address
  function automatic logic [AW-1:0] chunk_f(input logic [AW-1:0] a);
    return a & ~(AW'(`BP_FETCH_CHUNK) - AW'(1));
  endfunction : chunk_f

  // ==========================================================
  // reset synchroniser
  // ==========================================================
  // release two edges late, assert at once
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // prediction store and return stack
  // ==========================================================
  // returns use the stack; far never stored
  assign upd_go = ret_valid_in && is_near_f(ret_kind_in) &&
                  (ret_kind_in != bp_pkg::BP_K_RET);

  bp_pred_store #(
    .ENTRIES(ENTRIES),
    .AW(AW)
  ) u_store (
    .clock_in(clock_in),
    .rst_n_in(rst_n_q),
    .fa_addr_in(fetch_addr_in),
    .fa_hit_out(fa_hit),
    .fa_taken_out(fa_taken),
    .fa_target_out(fa_target),
    .da_addr_in(dec_addr_in),
    .da_hit_out(da_hit),
    .da_taken_out(da_taken),
    .da_target_out(da_target),
    .up_valid_in(upd_go),
    .up_addr_in(ret_addr_in),
    .up_taken_in(ret_taken_in),
    .up_target_in(ret_target_in)
  );

  bp_return_stack #(
    .DEPTH(RAS_DEPTH),
    .AW(AW)
  ) u_ras (
    .clock_in(clock_in),
    .rst_n_in(rst_n_q),
    .push_in(ras_push),
    .push_addr_in(fall_thru),
    .pop_in(ras_pop),
    .top_out(ras_top),
    .empty_out(ras_empty)
  );

  // ==========================================================
  // decode-stage prediction
  // ==========================================================
  // flush kills the same-cycle decode slot
  always_comb begin
    dec_go = dec_valid_in && !fl_q;
    fall_thru = dec_addr_in + AW'(dec_len_in);
    direct_tgt = fall_thru + dec_disp_in;
    near_d = is_near_f(dec_kind_in);
    static_d = 1'b0;
    taken_d = 1'b0;
    target_d = fall_thru;
    ras_push = 1'b0;
    ras_pop = 1'b0;
    unique case (dec_kind_in)
      bp_pkg::BP_K_COND: begin
        if (da_hit) begin
          // dynamic entry wins
          taken_d = da_taken;
          target_d = da_taken ? da_target : fall_thru;
        end else begin
          // negative displacement means backward
          static_d = 1'b1;
          taken_d = dec_disp_in[AW-1];
          target_d = dec_disp_in[AW-1] ? direct_tgt : fall_thru;
        end
      end
      bp_pkg::BP_K_CALL: begin
        // calls taken, push return address
        taken_d = 1'b1;
        target_d = da_hit ? da_target : direct_tgt;
        ras_push = dec_go;
      end
      bp_pkg::BP_K_RET: begin
        // always taken; target from the top of the stack
        taken_d = 1'b1;
        target_d = ras_top;
        ras_pop = dec_go;
      end
      bp_pkg::BP_K_IND: begin
        // no target without a dynamic entry
        taken_d = da_hit;
        target_d = da_hit ? da_target : fall_thru;
      end
      default: begin
        // not a branch or far: no prediction
        near_d = 1'b0;
      end
    endcase
  end

  // decode outputs, one cycle after the slot
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dv_q <= `BP_RST_FLAG;
      dm_q <= `BP_RST_FLAG;
      ds_q <= `BP_RST_FLAG;
      dt_q <= `BP_RST_FLAG;
      dtg_q <= `BP_RST_ADDR;
    end else begin
      dv_q <= dec_go;
      dm_q <= dec_go && near_d;
      ds_q <= dec_go && static_d;
      dt_q <= dec_go && near_d && taken_d;
      dtg_q <= target_d;
    end
  end

  // ==========================================================
  // trace building
  // ==========================================================
  // taken prediction joins trace to target
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tl_q <= `BP_RST_FLAG;
    end else begin
      tl_q <= dec_go && near_d && taken_d;
    end
  end

  // ==========================================================
  // fetch-stage prediction
  // ==========================================================
  // a hit steers fetch before decode
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fv_q <= `BP_RST_FLAG;
      fh_q <= `BP_RST_FLAG;
      ft_q <= `BP_RST_FLAG;
      ftg_q <= `BP_RST_ADDR;
      fnc_q <= `BP_RST_ADDR;
    end else begin
      fv_q <= fetch_valid_in && !fl_q;
      fh_q <= fetch_valid_in && fa_hit;
      ft_q <= fetch_valid_in && fa_hit && fa_taken;
      ftg_q <= fa_target;
      if (fetch_valid_in && fa_hit && fa_taken) begin
        // taken: next read starts at the target itself
        fnc_q <= fa_target;
      end else begin
        // sequential: next aligned chunk
        fnc_q <= chunk_f(fetch_addr_in) + AW'(`BP_FETCH_CHUNK);
      end
    end
  end

  // ==========================================================
  // misprediction recovery
  // ==========================================================
  // full refetch penalty accepted, not hidden
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fl_q <= `BP_RST_FLAG;
      rd_q <= `BP_RST_ADDR;
    end else begin
      fl_q <= ret_valid_in && ret_mispredict_in;
      if (ret_valid_in && ret_mispredict_in) begin
        rd_q <= ret_correct_addr_in;
      end
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign fetch_pred_valid_out = fv_q;
  assign fetch_pred_hit_out = fh_q;
  assign fetch_pred_taken_out = ft_q;
  assign fetch_pred_target_out = ftg_q;
  assign fetch_next_chunk_out = fnc_q;
  assign dec_pred_valid_out = dv_q;
  assign dec_pred_made_out = dm_q;
  assign dec_pred_static_out = ds_q;
  assign dec_pred_taken_out = dt_q;
  assign dec_pred_target_out = dtg_q;
  assign trace_link_out = tl_q;
  assign flush_out = fl_q;
  assign redirect_addr_out = rd_q;

endmodule : bp_branch_predictor

// >>> bench/bp_properties.sv
// Purpose: port checks on the branch predictor
// Assumes: bound into bp_branch_predictor, all on clock_in
// Notes: every output is registered one cycle after its cause
`timescale 1ns/1ps

module bp_checker #(
  parameter int AW = 32
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // fetch lookup
  input wire logic fetch_valid_in,
  input wire logic [AW-1:0] fetch_addr_in,
  input wire logic fetch_pred_valid_out,
  input wire logic fetch_pred_hit_out,
  input wire logic fetch_pred_taken_out,
  input wire logic [AW-1:0] fetch_next_chunk_out,
  // decode prediction
  input wire logic dec_valid_in,
  input wire logic [AW-1:0] dec_addr_in,
  input wire bp_pkg::bp_kind_e dec_kind_in,
  input wire logic [AW-1:0] dec_disp_in,
  input wire logic [3:0] dec_len_in,
  input wire logic dec_pred_valid_out,
  input wire logic dec_pred_made_out,
  input wire logic dec_pred_static_out,
  input wire logic dec_pred_taken_out,
  input wire logic [AW-1:0] dec_pred_target_out,
  input wire logic trace_link_out,
  // retirement and recovery
  input wire logic ret_valid_in,
  input wire logic ret_mispredict_in,
  input wire logic [AW-1:0] ret_correct_addr_in,
  input wire logic flush_out,
  input wire logic [AW-1:0] redirect_addr_out
);
  // ==========================================================
  // common timing
  // ==========================================================
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // live decode slot
  logic take_w;
  assign take_w = dec_valid_in && !flush_out;

  // ==========================================================
  // checks
  // ==========================================================
  fetch_echo_a: assert property (fetch_valid_in |=>
    fetch_pred_valid_out == !$past(flush_out))
    else $error("fetch echo wrong");
  fetch_chunk_a: assert property (fetch_pred_valid_out && !fetch_pred_taken_out |->
    fetch_next_chunk_out == ($past(fetch_addr_in) & {{(AW-5){1'h1}}, 5'h00}) + 32'h20)
    else $error("chunk wrong");
  taken_hit_a: assert property (fetch_pred_taken_out |-> fetch_pred_hit_out)
    else $error("taken without hit");
  near_made_a: assert property (take_w &&
    dec_kind_in inside {[bp_pkg::BP_K_COND:bp_pkg::BP_K_IND]} |=>
    dec_pred_valid_out && dec_pred_made_out)
    else $error("near not predicted");
  far_none_a: assert property (take_w &&
    dec_kind_in inside {[bp_pkg::BP_K_FAR_CALL:bp_pkg::BP_K_SWINT]} |=>
    dec_pred_valid_out && !dec_pred_made_out && !dec_pred_taken_out)
    else $error("far predicted");
  ret_taken_a: assert property (take_w && dec_kind_in == bp_pkg::BP_K_RET |=>
    dec_pred_taken_out)
    else $error("return not taken");
  static_dir_a: assert property (dec_pred_static_out |->
    dec_pred_taken_out == $past(dec_disp_in[AW-1]))
    else $error("static direction wrong");
  static_tgt_a: assert property (dec_pred_static_out && dec_pred_taken_out |->
    dec_pred_target_out == $past(dec_addr_in) + $past(dec_len_in) + $past(dec_disp_in))
    else $error("static target wrong");
  trace_link_a: assert property (dec_pred_valid_out |->
    trace_link_out == dec_pred_taken_out)
    else $error("trace link wrong");
  flush_a: assert property (ret_valid_in && ret_mispredict_in |=>
    flush_out && redirect_addr_out == $past(ret_correct_addr_in))
    else $error("no flush on mispredict");
  flush_cause_a: assert property (flush_out |->
    $past(ret_valid_in && ret_mispredict_in))
    else $error("flush without cause");
  drop_slot_a: assert property (dec_valid_in && flush_out |=> !dec_pred_valid_out)
    else $error("slot survived flush");
  redirect_hold_a: assert property (!(ret_valid_in && ret_mispredict_in) |=>
    $stable(redirect_addr_out))
    else $error("redirect moved");
endmodule : bp_checker

bind bp_branch_predictor bp_checker #(.AW(AW)) bp_checker_i (.*);

// >>> bench/bp_retire_model.sv
// Purpose: retirement unit model
// Assumes: one retire per call, started at a rising edge
// Notes: on release valid and mispredict clear, other fields show inverted values, except kind, which holds
`timescale 1ns/1ps

module bp_retire_model (
  // clock
  input wire logic clock_in,
  // retirement update
  output logic ret_valid_out,
  output logic [31:0] ret_addr_out,
  output bp_pkg::bp_kind_e ret_kind_out,
  output logic ret_taken_out,
  output logic [31:0] ret_target_out,
  output logic ret_mispredict_out,
  output logic [31:0] ret_correct_out
);
  // idle at time zero
  initial begin
    ret_valid_out = 1'h0;
    ret_addr_out = 32'h0;
    ret_kind_out = bp_pkg::BP_K_NONE;
    ret_taken_out = 1'h0;
    ret_target_out = 32'h0;
    ret_mispredict_out = 1'h0;
    ret_correct_out = 32'h0;
  end

  // one retired branch, resolved outcome only
  task automatic retire(input logic [31:0] a, t, c, input bp_pkg::bp_kind_e k,
                        input logic tk, m);
    @(posedge clock_in);
    ret_valid_out <= 1'h1;
    ret_addr_out <= a;
    ret_kind_out <= k;
    ret_taken_out <= tk;
    ret_target_out <= t;
    ret_mispredict_out <= m;
    ret_correct_out <= c;
    @(posedge clock_in);
    // release: valid and mispredict cleared, address, taken, target and correct inverted, kind kept
    ret_valid_out <= 1'h0;
    ret_addr_out <= ~a;
    ret_taken_out <= ~tk;
    ret_target_out <= ~t;
    ret_mispredict_out <= 1'h0;
    ret_correct_out <= ~c;
  endtask : retire
endmodule : bp_retire_model

// >>> bench/bp_testbench.sv
// Purpose: self-checking bench for the branch predictor
// Assumes: inputs change at rising edges
// Notes: one task per scenario, each judging itself
`timescale 1ns/1ps

module testbench;
  // ==========================================================
  // signals
  // ==========================================================
  logic clock_in = 1'h0;
  logic arst_n_in = 1'h0;
  int errors = 0;
  int compares = 0;
  // fetch side
  logic f_v = 1'h0;
  logic [31:0] f_a = 32'h0;
  logic fp_v, fp_h, fp_t;
  logic [31:0] fp_tg, fp_nc;
  // decode side
  logic d_v = 1'h0;
  logic [31:0] d_a = 32'h0, d_d = 32'h0;
  logic [3:0] d_l = 4'h0;
  bp_pkg::bp_kind_e d_k = bp_pkg::BP_K_NONE;
  logic dp_v, dp_m, dp_s, dp_t, link, flush;
  logic [31:0] dp_tg, redir;
  // retirement side, driven by the partner
  logic r_v, r_t, r_m;
  logic [31:0] r_a, r_tg, r_c;
  bp_pkg::bp_kind_e r_k;

  bp_branch_predictor bp_branch_predictor_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .fetch_valid_in(f_v), .fetch_addr_in(f_a), .fetch_pred_valid_out(fp_v),
    .fetch_pred_hit_out(fp_h), .fetch_pred_taken_out(fp_t), .fetch_pred_target_out(fp_tg),
    .fetch_next_chunk_out(fp_nc), .dec_valid_in(d_v), .dec_addr_in(d_a), .dec_kind_in(d_k),
    .dec_disp_in(d_d), .dec_len_in(d_l), .dec_pred_valid_out(dp_v), .dec_pred_made_out(dp_m),
    .dec_pred_static_out(dp_s), .dec_pred_taken_out(dp_t), .dec_pred_target_out(dp_tg),
    .trace_link_out(link), .ret_valid_in(r_v), .ret_addr_in(r_a), .ret_kind_in(r_k),
    .ret_taken_in(r_t), .ret_target_in(r_tg), .ret_mispredict_in(r_m),
    .ret_correct_addr_in(r_c), .flush_out(flush), .redirect_addr_out(redir));
  bp_retire_model bp_retire_model_i (.clock_in(clock_in), .ret_valid_out(r_v),
    .ret_addr_out(r_a), .ret_kind_out(r_k), .ret_taken_out(r_t), .ret_target_out(r_tg),
    .ret_mispredict_out(r_m), .ret_correct_out(r_c));

  // ==========================================================
  // shared tasks
  // ==========================================================
  // 250 MHz core clock
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, g);
    compares = compares + 1;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      errors = errors + 1;
    end
  endtask : chk
  // fetch lookup, checked a cycle on
  task automatic fet(input logic [31:0] a);
    @(posedge clock_in);
    f_v <= 1'h1;
    f_a <= a;
    @(posedge clock_in);
    f_v <= 1'h0;
    f_a <= ~a;
    #1;
  endtask : fet
  // decode slot, checked a cycle on
  task automatic dec(input bp_pkg::bp_kind_e k, input logic [31:0] a, d, input logic [3:0] l);
    @(posedge clock_in);
    d_v <= 1'h1;
    d_k <= k;
    d_a <= a;
    d_d <= d;
    d_l <= l;
    @(posedge clock_in);
    d_v <= 1'h0;
    d_a <= ~a;
    #1;
  endtask : dec
  // verdict and end of run
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // ==========================================================
  // scenarios
  // ==========================================================
  // empty store: static fallback
  task automatic t_static();
    fet(32'h1004);
    chk("fetch valid", 32'h1, fp_v);
    chk("fetch hit", 32'h0, fp_h);
    chk("fetch chunk", 32'h1020, fp_nc);
    dec(bp_pkg::BP_K_COND, 32'h1000, 32'hffff_fff0, 4'h2);
    chk("static flag", 32'h1, dp_s);
    chk("backward taken", 32'h1, dp_t);
    chk("backward target", 32'h0ff2, dp_tg);
    dec(bp_pkg::BP_K_COND, 32'h1000, 32'h40, 4'h2);
    chk("forward taken", 32'h0, dp_t);
    chk("forward target", 32'h1002, dp_tg);
    $display("test static done");
  endtask : t_static
  // every kind but none: near predicted, far not
  task automatic t_kinds();
    for (int i = 1; i < 8; i++) begin
      dec(bp_pkg::bp_kind_e'(3'(i)), 32'h1100, 32'h10, 4'h3);
      chk("slot valid", 32'h1, dp_v);
      chk("made", {31'h0, i < 5}, dp_m);
      if (i > 4) chk("far taken", 32'h0, dp_t);
    end
    $display("test kinds done");
  endtask : t_kinds
  // 16 nested calls, unwound
  task automatic t_stack();
    for (int i = 0; i < 16; i++) begin
      dec(bp_pkg::BP_K_CALL, 32'h2000 + 32'(i * 16), 32'h100, 4'h5);
      chk("call target", 32'h2105 + 32'(i * 16), dp_tg);
    end
    for (int i = 15; i >= 0; i--) begin
      dec(bp_pkg::BP_K_RET, 32'h3000, 32'h0, 4'h1);
      chk("return taken", 32'h1, dp_t);
      chk("return target", 32'h2005 + 32'(i * 16), dp_tg);
    end
    $display("test stack done");
  endtask : t_stack
  // retire fills store, then weakens
  task automatic t_dyn();
    bp_retire_model_i.retire(32'h4000, 32'h4800, 32'h0, bp_pkg::BP_K_COND, 1'h1, 1'h0);
    fet(32'h4000);
    chk("dyn hit", 32'h1, fp_h);
    chk("dyn taken", 32'h1, fp_t);
    chk("dyn target", 32'h4800, fp_tg);
    chk("dyn chunk", 32'h4800, fp_nc);
    dec(bp_pkg::BP_K_COND, 32'h4000, 32'h40, 4'h2);
    chk("dyn static", 32'h0, dp_s);
    chk("dyn dec target", 32'h4800, dp_tg);
    chk("trace link", 32'h1, link);
    bp_retire_model_i.retire(32'h4000, 32'h4800, 32'h0, bp_pkg::BP_K_COND, 1'h0, 1'h0);
    fet(32'h4000);
    chk("weakened taken", 32'h0, fp_t);
    $display("test dynamic done");
  endtask : t_dyn
  // mispredict: flush, redirect, drop
  task automatic t_flush();
    bp_retire_model_i.retire(32'h5000, 32'h5100, 32'h8000, bp_pkg::BP_K_COND, 1'h0, 1'h1);
    d_v <= 1'h1;
    d_k <= bp_pkg::BP_K_CALL;
    d_a <= 32'h6000;
    #1;
    chk("flush", 32'h1, flush);
    chk("redirect", 32'h8000, redir);
    @(posedge clock_in);
    d_v <= 1'h0;
    #1;
    chk("dropped slot", 32'h0, dp_v);
    chk("flush pulse", 32'h0, flush);
    chk("redirect hold", 32'h8000, redir);
    $display("test flush done");
  endtask : t_flush

  // ==========================================================
  // main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (10) @(posedge clock_in);
    arst_n_in <= 1'h1;
    repeat (3) @(posedge clock_in);
    t_static();
    t_kinds();
    t_stack();
    t_dyn();
    t_flush();
    conclude();
  end
  // tests take ~110 cycles
  initial begin
    repeat (5000) @(posedge clock_in);
    errors = errors + 1;
    conclude();
  end
endmodule : testbench
